// file: bjm_consts.svh
// Purpose: offsets, field positions, reset values and timing counts of the branch/jump/misc unit
// Assumes: included by bare name; definitions only
// Notes: register offsets are byte addresses on a 32-bit AHB-Lite bus
`ifndef BJM_CONSTS_SVH
`define BJM_CONSTS_SVH
`define BJM_ADDR_INSTR      8'h00
`define BJM_ADDR_OPND_A     8'h04
`define BJM_ADDR_OPND_B     8'h08
`define BJM_ADDR_PC         8'h0c
`define BJM_ADDR_RESULT     8'h10
`define BJM_ADDR_FLAGS      8'h14
`define BJM_ADDR_NEXT_PC    8'h18
`define BJM_ADDR_QUOT       8'h1c
`define BJM_ADDR_REM        8'h20
`define BJM_ADDR_STATUS     8'h24
`define BJM_ADDR_EXC_RET    8'h28
`define BJM_ADDR_ERR_RET    8'h2c
`define BJM_ADDR_DBG_RET    8'h30
`define BJM_ADDR_MODE       8'h34
`define BJM_ADDR_DEST       8'h38
`define BJM_ADDR_COP2_BASE  8'h40
`define BJM_COP2_ENTRIES    4
`define BJM_STATUS_IRQEN_BIT 0
`define BJM_STATUS_EXL_BIT  1
`define BJM_STATUS_ERL_BIT  2
`define BJM_MODE_DEBUG_BIT  0
`define BJM_MODE_LINK_BIT   1
`define BJM_MODE_COMPACT_BIT 2
`define BJM_LINK_GPR        5'h1f
`define BJM_LINK_STEP       32'h00000008
`define BJM_LINK_STEP_C     32'h00000002
`define BJM_PC_STEP         32'h00000004
`define BJM_DIV_STEPS       6'h20
`define BJM_HAZARD_CYCLES   3'h3
`define BJM_RESET_WORD      32'h00000000
`endif

// file: bjm_pkg.sv
// Purpose: types shared by the branch/jump/misc unit
// Assumes: opcode field sits in instruction bits 31:26
// Notes: opcode values are local to this unit
package bjm_pkg;
  typedef enum logic [5:0] {
    OP_NOP                  = 6'h00,
    OP_BRANCH_EQUAL_LIKELY  = 6'h01,
    OP_BRANCH_NONNEG        = 6'h02,
    OP_BRANCH_NONNEG_L      = 6'h03,
    OP_BRANCH_NONNEG_LINK   = 6'h04,
    OP_BRANCH_NONNEG_LINK_L = 6'h05,
    OP_BRANCH_POSITIVE      = 6'h06,
    OP_BRANCH_POSITIVE_L    = 6'h07,
    OP_BRANCH_NONPOS        = 6'h08,
    OP_BRANCH_NONPOS_L      = 6'h09,
    OP_BRANCH_NEGATIVE      = 6'h0a,
    OP_BRANCH_NEGATIVE_L    = 6'h0b,
    OP_BRANCH_NEG_LINK      = 6'h0c,
    OP_BRANCH_NEG_LINK_L    = 6'h0d,
    OP_BRANCH_UNEQUAL       = 6'h0e,
    OP_BRANCH_UNEQUAL_L     = 6'h0f,
    OP_COP_TWO_CTRL_READ    = 6'h10,
    OP_COP_TWO_CTRL_WRITE   = 6'h11,
    OP_DEBUG_RETURN         = 6'h12,
    OP_GLOBAL_IRQ_OFF       = 6'h13,
    OP_GLOBAL_IRQ_ON        = 6'h14,
    OP_SIGNED_QUOTIENT      = 6'h15,
    OP_UNSIGNED_QUOTIENT    = 6'h16,
    OP_EXEC_HAZARD_BARRIER  = 6'h17,
    OP_EXCEPTION_RETURN     = 6'h18,
    OP_BITFIELD_PULL        = 6'h19,
    OP_BITFIELD_PUT         = 6'h1a,
    OP_PC_REGION_TRANSFER   = 6'h1b,
    OP_PC_REGION_XFER_LINK  = 6'h1c,
    OP_REG_TARGET_CALL      = 6'h1d,
    OP_REG_TARGET_CALL_BAR  = 6'h1e,
    OP_REG_TARGET_CALL_CMP  = 6'h1f,
    OP_REG_TARGET_XFER      = 6'h20,
    OP_REG_TARGET_XFER_BAR  = 6'h21
  } bjm_op_type;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_DIVIDE  = 3'b010,
    ST_BARRIER = 3'b100
  } bjm_state_type;
endpackage : bjm_pkg

// file: bjm_exec_unit.sv
// Purpose: execution of branches, jumps, divide, bit fields, irq on/off, returns and cop2 control moves
// Assumes: AHB-Lite single word transfers; operands and pc loaded by software before the instruction word
// Notes: rules follow
// Operation
// RULE1 - equal likely: branch if equal, else annul
// RULE2 - nonnegative branches on clear bit 31
// RULE3 - nonnegative link always writes pc+8 to r31
// RULE4 - positive: bit 31 clear and nonzero
// RULE5 - nonpositive: bit 31 set or zero
// RULE6 - negative branches on set bit 31
// RULE7 - negative link always writes pc+8 to r31
// RULE8 - unequal branches when operands differ
// RULE9 - cop2 control word read into gpr
// RULE10 - gpr written into cop2 control word
// RULE11 - debug return: pc from saved address, leave debug
// RULE12 - irq off: copy status, clear enable
// RULE13 - irq on: copy status, set enable
// RULE14 - divide: quotient low, remainder high
// RULE15 - hazard barrier stalls until hazards clear
// RULE16 - exception return picks address, clears bits, link
// RULE17 - bit field extract right aligned
// RULE18 - bit field insert keeps other bits
// RULE19 - region jump: pc top bits plus offset
// RULE20 - register call links pc+8, jumps source
// RULE21 - compact call: no slot, links pc+2
// RULE22 - barrier jump forms also clear hazards
// RULE23 - delay slot executes; offset relative to slot
//
// The address map and the AHB-Lite register port were left to the implementer.
`include "bjm_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module bjm_exec_unit (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp
);
  import bjm_pkg::*;

  function automatic logic isLikely(input bjm_op_type op);
    case (op)
      OP_BRANCH_EQUAL_LIKELY, OP_BRANCH_NONNEG_L, OP_BRANCH_NONNEG_LINK_L, OP_BRANCH_POSITIVE_L,
      OP_BRANCH_NONPOS_L, OP_BRANCH_NEGATIVE_L, OP_BRANCH_NEG_LINK_L, OP_BRANCH_UNEQUAL_L: isLikely = 1'b1;
      default: isLikely = 1'b0;
    endcase
  endfunction : isLikely

  function automatic logic isCondBranch(input bjm_op_type op);
    isCondBranch = (op >= OP_BRANCH_EQUAL_LIKELY) && (op <= OP_BRANCH_UNEQUAL_L);
  endfunction : isCondBranch

  function automatic logic isBarrier(input bjm_op_type op);
    isBarrier = (op == OP_EXEC_HAZARD_BARRIER) || (op == OP_REG_TARGET_CALL_BAR) || (op == OP_REG_TARGET_XFER_BAR);
  endfunction : isBarrier

  function automatic logic branchTaken(input bjm_op_type op, input logic [31:0] a, input logic [31:0] b);
    case (op)
      OP_BRANCH_EQUAL_LIKELY: branchTaken = (a == b);
      OP_BRANCH_NONNEG, OP_BRANCH_NONNEG_L, OP_BRANCH_NONNEG_LINK, OP_BRANCH_NONNEG_LINK_L: branchTaken = !a[31];
      OP_BRANCH_POSITIVE, OP_BRANCH_POSITIVE_L: branchTaken = !a[31] && (a != 32'h00000000);
      OP_BRANCH_NONPOS, OP_BRANCH_NONPOS_L: branchTaken = a[31] || (a == 32'h00000000);
      OP_BRANCH_NEGATIVE, OP_BRANCH_NEGATIVE_L, OP_BRANCH_NEG_LINK, OP_BRANCH_NEG_LINK_L: branchTaken = a[31];
      OP_BRANCH_UNEQUAL, OP_BRANCH_UNEQUAL_L: branchTaken = (a != b);
      default: branchTaken = 1'b0;
    endcase
  endfunction : branchTaken

  logic          addrPhase;
  logic          wrPendQ;
  logic          rdPendQ;
  logic [7:0]    addrQ;
  logic          issueNow;
  logic          goQ;
  logic [31:0]   instrQ;
  logic [31:0]   opndAQ;
  logic [31:0]   opndBQ;
  logic [31:0]   pcQ;
  logic [31:0]   statusQ;
  logic [31:0]   excRetQ;
  logic [31:0]   errRetQ;
  logic [31:0]   dbgRetQ;
  logic [2:0]    modeQ;
  logic [31:0]   cop2Q [`BJM_COP2_ENTRIES];
  logic [31:0]   resultQ;
  logic [4:0]    destQ;
  logic          wrEnQ;
  logic          takenQ;
  logic          annulQ;
  logic          illegalQ;
  logic [31:0]   nextPcQ;
  logic          slotQ;
  logic [31:0]   slotTargetQ;
  logic [31:0]   quotQ;
  logic [31:0]   remQ;
  logic [2:0]    hazardQ;
  bjm_state_type stateQ;
  bjm_op_type    op;
  logic          busy;
  logic          hazardActive;
  logic          doExec;
  logic [5:0]    divCntQ;
  logic [31:0]   divRemQ;
  logic [31:0]   divQuoQ;
  logic [31:0]   divisorQ;
  logic          negQuoQ;
  logic          negRemQ;
  logic [32:0]   remShift;
  logic [32:0]   remDiff;
  logic [31:0]   resD;
  logic [4:0]    destD;
  logic          wrEnD;
  logic          takenD;
  logic          annulD;
  logic          illegalD;
  logic [31:0]   nextPcD;
  logic          slotD;
  logic [31:0]   targetD;
  logic [31:0]   branchOff;
  logic [31:0]   fieldMask;
  logic [1:0]    cop2Sel;

  assign op           = bjm_op_type'(instrQ[31:26]);
  assign addrPhase    = hsel && htrans[1] && hready;
  assign busy         = goQ || (stateQ != ST_IDLE);
  assign issueNow     = wrPendQ && (addrQ == `BJM_ADDR_INSTR) && !busy;
  assign hazardActive = (hazardQ != 3'h0);
  assign cop2Sel      = instrQ[12:11];
  // offset counts words from the delay-slot address
  assign branchOff    = {{14{instrQ[15]}}, instrQ[15:0], 2'b00}; // [RULE23]
  assign fieldMask    = 32'hffffffff >> (5'd31 - instrQ[15:11]);

  // bus slave: writes take no wait state, reads take one so read data leaves a flop
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      wrPendQ   <= 1'b0;
      rdPendQ   <= 1'b0;
      addrQ     <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wrPendQ   <= addrPhase && hwrite;
      rdPendQ   <= addrPhase && !hwrite;
      hreadyout <= !(addrPhase && !hwrite);
      hresp     <= 1'b0;
      if (addrPhase)
        addrQ <= haddr[7:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      hrdata <= 32'h00000000;
    else if (rdPendQ)
    begin
      case (addrQ)
        `BJM_ADDR_INSTR:   hrdata <= instrQ;
        `BJM_ADDR_OPND_A:  hrdata <= opndAQ;
        `BJM_ADDR_OPND_B:  hrdata <= opndBQ;
        `BJM_ADDR_PC:      hrdata <= pcQ;
        `BJM_ADDR_RESULT:  hrdata <= resultQ;
        `BJM_ADDR_FLAGS:   hrdata <= {24'h000000, illegalQ, modeQ[`BJM_MODE_DEBUG_BIT], slotQ, wrEnQ,
                                      annulQ, takenQ, hazardActive, busy};
        `BJM_ADDR_NEXT_PC: hrdata <= nextPcQ;
        `BJM_ADDR_QUOT:    hrdata <= quotQ;
        `BJM_ADDR_REM:     hrdata <= remQ;
        `BJM_ADDR_STATUS:  hrdata <= statusQ;
        `BJM_ADDR_EXC_RET: hrdata <= excRetQ;
        `BJM_ADDR_ERR_RET: hrdata <= errRetQ;
        `BJM_ADDR_DBG_RET: hrdata <= dbgRetQ;
        `BJM_ADDR_MODE:    hrdata <= {29'h00000000, modeQ};
        `BJM_ADDR_DEST:    hrdata <= {27'h0000000, destQ};
        `BJM_ADDR_COP2_BASE, 8'h44, 8'h48, 8'h4c: hrdata <= cop2Q[addrQ[3:2]];
        default:           hrdata <= 32'h00000000;
      endcase
    end
  end

  // software-only registers; an instruction word written while busy is dropped
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      instrQ <= `BJM_RESET_WORD;
      opndAQ <= `BJM_RESET_WORD;
      opndBQ <= `BJM_RESET_WORD;
      goQ    <= 1'b0;
    end
    else
    begin
      goQ <= issueNow;
      if (issueNow)
        instrQ <= hwdata;
      if (wrPendQ && addrQ == `BJM_ADDR_OPND_A)
        opndAQ <= hwdata;
      if (wrPendQ && addrQ == `BJM_ADDR_OPND_B)
        opndBQ <= hwdata;
    end
  end

  // sequencer: divide iterates, barriers wait for hazards
  always_ff @(posedge mclk)
  begin
    if (srst)
      stateQ <= ST_IDLE;
    else
    begin
      case (stateQ)
        ST_IDLE:
          if (goQ && (op == OP_SIGNED_QUOTIENT || op == OP_UNSIGNED_QUOTIENT))
            stateQ <= ST_DIVIDE;
          else if (goQ && isBarrier(op) && hazardActive)
            stateQ <= ST_BARRIER; // [RULE15] [RULE22]
        ST_DIVIDE:
          if (divCntQ == 6'h00)
            stateQ <= ST_IDLE;
        ST_BARRIER:
          if (!hazardActive)
            stateQ <= ST_IDLE;
        default: stateQ <= ST_IDLE;
      endcase
    end
  end

  always_comb
  begin
    doExec = 1'b0;
    case (stateQ)
      ST_IDLE:    doExec = goQ && op != OP_SIGNED_QUOTIENT && op != OP_UNSIGNED_QUOTIENT
                           && !(isBarrier(op) && hazardActive);
      ST_DIVIDE:  doExec = (divCntQ == 6'h00);
      ST_BARRIER: doExec = !hazardActive;
      default:    doExec = 1'b0;
    endcase
  end

  // restoring divider on magnitudes, signs restored at the end
  assign remShift = {divRemQ, divQuoQ[31]};
  assign remDiff  = remShift - {1'b0, divisorQ};

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      divCntQ  <= 6'h00;
      divRemQ  <= 32'h00000000;
      divQuoQ  <= 32'h00000000;
      divisorQ <= 32'h00000000;
      negQuoQ  <= 1'b0;
      negRemQ  <= 1'b0;
    end
    else if (stateQ == ST_IDLE && goQ && (op == OP_SIGNED_QUOTIENT || op == OP_UNSIGNED_QUOTIENT))
    begin
      divCntQ  <= `BJM_DIV_STEPS;
      divRemQ  <= 32'h00000000;
      negQuoQ  <= (op == OP_SIGNED_QUOTIENT) && (opndAQ[31] ^ opndBQ[31]);
      negRemQ  <= (op == OP_SIGNED_QUOTIENT) && opndAQ[31];
      divQuoQ  <= (op == OP_SIGNED_QUOTIENT && opndAQ[31]) ? 32'(-opndAQ) : opndAQ;
      divisorQ <= (op == OP_SIGNED_QUOTIENT && opndBQ[31]) ? 32'(-opndBQ) : opndBQ;
    end
    else if (stateQ == ST_DIVIDE && divCntQ != 6'h00)
    begin
      divCntQ <= divCntQ - 6'h01;
      divRemQ <= remDiff[32] ? remShift[31:0] : remDiff[31:0];
      divQuoQ <= {divQuoQ[30:0], !remDiff[32]};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      quotQ <= 32'h00000000;
      remQ  <= 32'h00000000;
    end
    else if (doExec && stateQ == ST_DIVIDE)
    begin
      quotQ <= negQuoQ ? 32'(-divQuoQ) : divQuoQ; // [RULE14]
      remQ  <= negRemQ ? 32'(-divRemQ) : divRemQ; // [RULE14]
    end
  end

  // result of one instruction
  always_comb
  begin
    resD     = 32'h00000000;
    destD    = instrQ[20:16];
    wrEnD    = 1'b0;
    takenD   = 1'b0;
    annulD   = 1'b0;
    illegalD = 1'b0;
    slotD    = 1'b0;
    targetD  = 32'h00000000;
    nextPcD  = pcQ + `BJM_PC_STEP;
    if (isCondBranch(op))
    begin
      takenD  = branchTaken(op, opndAQ, opndBQ); // [RULE1] [RULE2] [RULE4] [RULE5] [RULE6] [RULE8]
      targetD = pcQ + `BJM_PC_STEP + branchOff; // [RULE23]
      slotD   = takenD;
      annulD  = isLikely(op) && !takenD; // [RULE1] [RULE2] [RULE4] [RULE5] [RULE6] [RULE8]
      if (annulD)
        nextPcD = pcQ + `BJM_LINK_STEP;
      if (op == OP_BRANCH_NONNEG_LINK || op == OP_BRANCH_NONNEG_LINK_L
          || op == OP_BRANCH_NEG_LINK || op == OP_BRANCH_NEG_LINK_L)
      begin
        wrEnD = 1'b1; // [RULE3] [RULE7]
        destD = `BJM_LINK_GPR;
        resD  = pcQ + `BJM_LINK_STEP;
      end
    end
    else
    begin
      case (op)
        OP_COP_TWO_CTRL_READ:
        begin
          wrEnD = 1'b1;
          resD  = cop2Q[cop2Sel]; // [RULE9]
        end
        OP_GLOBAL_IRQ_OFF, OP_GLOBAL_IRQ_ON:
        begin
          wrEnD = 1'b1;
          resD  = statusQ; // [RULE12] [RULE13]
        end
        OP_BITFIELD_PULL:
        begin
          wrEnD = 1'b1;
          resD  = (opndAQ >> instrQ[10:6]) & fieldMask; // [RULE17]
        end
        OP_BITFIELD_PUT:
        begin
          wrEnD = 1'b1;
          resD  = (opndBQ & ~(fieldMask << instrQ[10:6])) | ((opndAQ << instrQ[10:6]) & (fieldMask << instrQ[10:6])); // [RULE18]
        end
        OP_PC_REGION_TRANSFER, OP_PC_REGION_XFER_LINK:
        begin
          slotD   = 1'b1;
          takenD  = 1'b1;
          targetD = {pcQ[31:28], instrQ[25:0], 2'b00}; // [RULE19]
          wrEnD   = (op == OP_PC_REGION_XFER_LINK);
          destD   = `BJM_LINK_GPR;
          resD    = pcQ + `BJM_LINK_STEP;
        end
        OP_REG_TARGET_CALL, OP_REG_TARGET_CALL_BAR, OP_REG_TARGET_XFER, OP_REG_TARGET_XFER_BAR:
        begin
          slotD   = 1'b1; // [RULE22] [RULE23]
          takenD  = 1'b1;
          targetD = opndAQ; // [RULE20]
          wrEnD   = (op == OP_REG_TARGET_CALL || op == OP_REG_TARGET_CALL_BAR);
          destD   = instrQ[15:11];
          resD    = pcQ + `BJM_LINK_STEP; // [RULE20]
        end
        OP_REG_TARGET_CALL_CMP:
        begin
          // only legal in compressed mode; otherwise the illegal flag is set, no link is written and pc steps by 4
          illegalD = !modeQ[`BJM_MODE_COMPACT_BIT];
          takenD   = !illegalD;
          wrEnD    = !illegalD;
          destD    = instrQ[15:11];
          resD     = pcQ + `BJM_LINK_STEP_C; // [RULE21]
          nextPcD  = illegalD ? pcQ + `BJM_PC_STEP : opndAQ; // [RULE21]
        end
        OP_DEBUG_RETURN:
        begin
          takenD  = 1'b1;
          nextPcD = dbgRetQ; // [RULE11]
        end
        OP_EXCEPTION_RETURN:
        begin
          takenD  = 1'b1;
          nextPcD = statusQ[`BJM_STATUS_ERL_BIT] ? errRetQ : excRetQ; // [RULE16]
        end
        default: wrEnD = 1'b0;
      endcase
    end
  end

  // program flow: a pending slot target takes over after the delay-slot instruction
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      resultQ     <= 32'h00000000;
      destQ       <= 5'h00;
      wrEnQ       <= 1'b0;
      takenQ      <= 1'b0;
      annulQ      <= 1'b0;
      illegalQ    <= 1'b0;
      nextPcQ     <= 32'h00000000;
      slotQ       <= 1'b0;
      slotTargetQ <= 32'h00000000;
    end
    else if (doExec)
    begin
      resultQ     <= resD;
      destQ       <= destD;
      wrEnQ       <= wrEnD;
      takenQ      <= takenD;
      annulQ      <= annulD;
      illegalQ    <= illegalD;
      slotQ       <= slotD;
      slotTargetQ <= targetD;
      nextPcQ     <= slotQ ? slotTargetQ : nextPcD; // [RULE23]
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      pcQ <= 32'h00000000;
    else if (wrPendQ && addrQ == `BJM_ADDR_PC)
      pcQ <= hwdata;
    else if (doExec)
      pcQ <= slotQ ? slotTargetQ : nextPcD;
  end

  // status word; irq on/off and exception return are single-cycle read-modify-write
  always_ff @(posedge mclk)
  begin
    if (srst)
      statusQ <= 32'h00000000;
    else if (doExec && op == OP_GLOBAL_IRQ_OFF)
      statusQ[`BJM_STATUS_IRQEN_BIT] <= 1'b0; // [RULE12]
    else if (doExec && op == OP_GLOBAL_IRQ_ON)
      statusQ[`BJM_STATUS_IRQEN_BIT] <= 1'b1; // [RULE13]
    else if (doExec && op == OP_EXCEPTION_RETURN)
    begin
      if (statusQ[`BJM_STATUS_ERL_BIT])
        statusQ[`BJM_STATUS_ERL_BIT] <= 1'b0; // [RULE16]
      else
        statusQ[`BJM_STATUS_EXL_BIT] <= 1'b0; // [RULE16]
    end
    else if (wrPendQ && addrQ == `BJM_ADDR_STATUS)
      statusQ <= hwdata;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      excRetQ <= 32'h00000000;
      errRetQ <= 32'h00000000;
      dbgRetQ <= 32'h00000000;
    end
    else
    begin
      if (wrPendQ && addrQ == `BJM_ADDR_EXC_RET)
        excRetQ <= hwdata;
      if (wrPendQ && addrQ == `BJM_ADDR_ERR_RET)
        errRetQ <= hwdata;
      if (wrPendQ && addrQ == `BJM_ADDR_DBG_RET)
        dbgRetQ <= hwdata;
    end
  end

  // mode bits: the instruction's clear beats a same-cycle software write
  always_ff @(posedge mclk)
  begin
    if (srst)
      modeQ <= 3'h0;
    else
    begin
      if (wrPendQ && addrQ == `BJM_ADDR_MODE)
        modeQ <= hwdata[2:0];
      if (doExec && op == OP_DEBUG_RETURN)
        modeQ[`BJM_MODE_DEBUG_BIT] <= 1'b0; // [RULE11]
      if (doExec && op == OP_EXCEPTION_RETURN)
        modeQ[`BJM_MODE_LINK_BIT] <= 1'b0; // [RULE16]
    end
  end

  for (genvar i = 0; i < `BJM_COP2_ENTRIES; i++)
  begin : gCop2
    always_ff @(posedge mclk)
    begin
      if (srst)
        cop2Q[i] <= 32'h00000000;
      else if (doExec && op == OP_COP_TWO_CTRL_WRITE && cop2Sel == 2'(i))
        cop2Q[i] <= opndBQ; // [RULE10]
      else if (wrPendQ && addrQ == 8'(`BJM_ADDR_COP2_BASE + 4 * i))
        cop2Q[i] <= hwdata;
    end
  end

  // state changes leave a short hazard window that barriers wait out
  always_ff @(posedge mclk)
  begin
    if (srst)
      hazardQ <= 3'h0;
    else if ((doExec && (op == OP_GLOBAL_IRQ_OFF || op == OP_GLOBAL_IRQ_ON || op == OP_EXCEPTION_RETURN
             || op == OP_DEBUG_RETURN || op == OP_COP_TWO_CTRL_WRITE))
             || (wrPendQ && addrQ == `BJM_ADDR_STATUS))
      hazardQ <= `BJM_HAZARD_CYCLES;
    else if (hazardActive)
      hazardQ <= hazardQ - 3'h1;
  end

  chk_likely_annul: assert property (@(posedge mclk) disable iff (srst) // [RULE1]
    doExec && op == OP_BRANCH_EQUAL_LIKELY && opndAQ != opndBQ |=> annulQ && !takenQ && nextPcQ == $past(pcQ) + 32'h8)
    else $error("equal likely not annulled");
  chk_nonneg_take: assert property (@(posedge mclk) disable iff (srst) // [RULE2]
    doExec && op == OP_BRANCH_NONNEG |=> takenQ == !$past(opndAQ[31]))
    else $error("nonnegative branch decision wrong");
  chk_link_always: assert property (@(posedge mclk) disable iff (srst) // [RULE3]
    doExec && op == OP_BRANCH_NONNEG_LINK |=> wrEnQ && destQ == 5'h1f && resultQ == $past(pcQ) + 32'h8)
    else $error("link not written");
  chk_positive_take: assert property (@(posedge mclk) disable iff (srst) // [RULE4]
    doExec && op == OP_BRANCH_POSITIVE_L && (opndAQ[31] || opndAQ == 32'h0) |=> !takenQ && annulQ)
    else $error("positive likely taken wrongly");
  chk_irq_off: assert property (@(posedge mclk) disable iff (srst) // [RULE12]
    doExec && op == OP_GLOBAL_IRQ_OFF |=> !statusQ[0] && resultQ == $past(statusQ))
    else $error("irq off failed");
  chk_div_result: assert property (@(posedge mclk) disable iff (srst) // [RULE14]
    stateQ == ST_IDLE && goQ && op == OP_UNSIGNED_QUOTIENT && opndBQ != 32'h0
    |-> ##34 quotQ == $past(opndAQ, 34) / $past(opndBQ, 34) && remQ == $past(opndAQ, 34) % $past(opndBQ, 34))
    else $error("unsigned divide wrong");
  chk_barrier_hold: assert property (@(posedge mclk) disable iff (srst) // [RULE15]
    doExec && isBarrier(op) |-> hazardQ == 3'h0)
    else $error("barrier completed with hazard");
  chk_error_return: assert property (@(posedge mclk) disable iff (srst) // [RULE16]
    doExec && op == OP_EXCEPTION_RETURN && statusQ[2] |=> nextPcQ == $past(errRetQ) && !statusQ[2] && !modeQ[1])
    else $error("error return path wrong");
  chk_compact_noslot: assert property (@(posedge mclk) disable iff (srst) // [RULE21]
    doExec && op == OP_REG_TARGET_CALL_CMP && modeQ[2] && !slotQ |=> !slotQ && nextPcQ == $past(opndAQ))
    else $error("compact call used a slot");
  chk_slot_follow: assert property (@(posedge mclk) disable iff (srst) // [RULE23]
    doExec && slotQ |=> nextPcQ == $past(slotTargetQ))
    else $error("delay slot target lost");
endmodule : bjm_exec_unit
`default_nettype wire

// file: test_branch_jump_misc_exec.sv
// Purpose: self-checking bench of bjm_exec_unit
// Assumes: AHB-Lite single words; hready is the slave's own hreadyout
// Notes: expected values come from an integer model kept in the bench
`timescale 1ns/1ns
`default_nettype none
module test_branch_jump_misc_exec;
  import bjm_pkg::*;
  logic        mclk = 0, srst = 1, hsel = 0, hwrite = 0, rdy, hresp;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, v, a, b, p, x, m;
  int          n_mismatch = 0, checked = 0, t, o, pos, sz;
  always #20 mclk = ~mclk;
  bjm_exec_unit u_dut (.mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hrdata(hrdata),
    .hreadyout(rdy), .hresp(hresp));
  task automatic chk(string s, logic [31:0] seen, logic [31:0] e);
    checked++;
    if (seen !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", s, e, seen);
    end
  endtask : chk
  // no wait count is assumed; only the watchdog ends a stuck hready
  task automatic bus(logic w, logic [7:0] ad, logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge mclk); while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (rdy !== 1'b1);
    v = hrdata;
  endtask : bus
  task automatic rc(string s, logic [7:0] ad, logic [31:0] e);
    bus(1'b0, ad, 32'h0);
    chk(s, v, e);
  endtask : rc
  // a divide needs 34 cycles, so 40 polls of busy leave room
  task automatic ex(logic [31:0] word);
    bus(1'b1, 8'h00, word);
    v = 32'h1;
    for (int i = 0; i < 40 && v[0] !== 1'b0; i++)
      bus(1'b0, 8'h14, 32'h0);
    chk("busy", v[0], 1'b0);
  endtask : ex
  task automatic go(logic [31:0] word, logic [31:0] aa, logic [31:0] bb, logic [31:0] pc);
    bus(1'b1, 8'h04, aa);
    bus(1'b1, 8'h08, bb);
    bus(1'b1, 8'h0c, pc);
    ex(word);
  endtask : go
  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    complete_run();
  end
  initial
  begin
    v = $urandom(32'h92c0);
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    for (o = 1; o < 16; o++)
      repeat (4)
      begin
        a = ($urandom % 3 == 0) ? $urandom : {$urandom % 2 == 1, 30'h0, $urandom % 2 == 1};
        b = ($urandom % 2) ? a : $urandom;
        p = $urandom & 32'h0ffffffc;
        m = $urandom;
        x = p + 32'h4 + ({{16{m[15]}}, m[15:0]} << 2);
        t = o == 1 ? a == b : o > 13 ? a != b : o < 6 ? !a[31] : o < 8 ? !a[31] && a != 0 :
          o < 10 ? a[31] || a == 0 : a[31];
        go({o[5:0], 10'h0, m[15:0]}, a, b, p);
        chk("taken", v[2], t);
        chk("annul", v[3], o[0] && !t);
        if (o inside {4, 5, 12, 13})
          rc("link", 8'h10, p + 32'h8);
        rc("next", 8'h18, p + (o[0] && !t ? 32'h8 : 32'h4));
        if (!(o[0] && !t))
          ex(32'h0);
        if (!(o[0] && !t))
          rc("slot", 8'h18, t ? x : p + 32'h8);
      end
    $display("branches done");
    for (o = 21; o < 23; o++)
      repeat (4)
      begin
        a = $urandom;
        b = $urandom % 4000 + 1;
        b = ($urandom % 2) ? -b : b;
        go({o[5:0], 26'h0}, a, b, 32'h0);
        x = $signed(a) / $signed(b);
        m = $signed(a) % $signed(b);
        rc("quot", 8'h1c, o == 22 ? a / b : x);
        rc("rem", 8'h20, o == 22 ? a % b : m);
      end
    for (o = 19; o < 21; o++)
    begin
      a = $urandom % 8;
      bus(1'b1, 8'h24, a);
      ex({o[5:0], 5'h0, 5'h3, 16'h0});
      rc("copy", 8'h10, a);
      rc("irq enable", 8'h24, o == 19 ? a & 32'h6 : a | 32'h1);
      // no busy poll here, so the barrier lands inside the fresh hazard window
      bus(1'b1, 8'h00, {o[5:0], 5'h0, 5'h3, 16'h0});
      ex({6'h17, 26'h0});
      chk("hazard", v[1], 1'b0);
    end
    for (o = 0; o < 2; o++)
    begin
      x = $urandom;
      m = $urandom;
      bus(1'b1, 8'h24, {29'h0, o[0], 2'h3});
      bus(1'b1, 8'h28, x);
      bus(1'b1, 8'h2c, m);
      bus(1'b1, 8'h34, 32'h3);
      ex({6'h18, 26'h0});
      rc("exc return pc", 8'h18, o ? m : x);
      rc("exc return status", 8'h24, o ? 32'h3 : 32'h1);
      rc("exc return link", 8'h34, 32'h1);
      bus(1'b1, 8'h30, x);
      ex({6'h12, 26'h0});
      rc("dbg return pc", 8'h18, x);
      rc("dbg return mode", 8'h34, 32'h0);
    end
    $display("divide, irq and returns done");
    repeat (6)
    begin
      pos = $urandom % 32;
      sz = $urandom % (32 - pos) + 1;
      m = 32'hffffffff >> (32 - sz);
      a = $urandom;
      b = $urandom;
      go({6'h19, 5'h0, 5'h2, 5'(sz - 1), 5'(pos), 6'h0}, a, b, 32'h0);
      rc("pull", 8'h10, (a >> pos) & m);
      ex({6'h1a, 5'h0, 5'h2, 5'(sz - 1), 5'(pos), 6'h0});
      rc("put", 8'h10, (b & ~(m << pos)) | ((a & m) << pos));
    end
    for (o = 0; o < 4; o++)
    begin
      b = $urandom;
      go({6'h11, 10'h0, 3'h0, o[1:0], 11'h0}, a, b, 32'h0);
      rc("cop2 word", 8'h40 + 8'(o * 4), b);
      ex({6'h10, 5'h0, 5'h4, 3'h0, o[1:0], 11'h0});
      rc("cop2 read", 8'h10, b);
    end
    $display("fields and cop2 done");
    a = $urandom & 32'hfffffffc;
    p = $urandom & 32'hfffffffc;
    m = $urandom;
    for (o = 27; o < 29; o++)
    begin
      go({o[5:0], m[25:0]}, a, b, p);
      chk("region wren", v[4], o == 28);
      if (o == 28)
        rc("region link", 8'h10, p + 32'h8);
      ex(32'h0);
      rc("region pc", 8'h18, {p[31:28], m[25:0], 2'h0});
    end
    for (o = 29; o < 34; o++)
    begin
      bus(1'b1, 8'h34, {29'h0, o == 31, 2'h0});
      go({o[5:0], 10'h0, 5'h7, 11'h0}, a, b, p);
      chk("call wren", v[4], o < 32);
      if (o < 32)
        rc("call link", 8'h10, p + (o == 31 ? 32'h2 : 32'h8));
      if (o < 32)
        rc("call dest", 8'h38, 32'h7);
      // the compact form has no slot, so its target shows at once
      if (o != 31)
        ex(32'h0);
      rc("call pc", 8'h18, a);
    end
    $display("jumps done");
    complete_run();
  end
endmodule : test_branch_jump_misc_exec
`default_nettype wire
